// ===== rtl/rtq_alarm_qual.sv
// Alarm qualifiers, clock block control and spring-forward daylight-saving logic
//
// Decided for this implementation: the plain strobed port.
`timescale 1ns/100ps
// Behaviour
// - Nonzero month qualifier must equal month counter
// - Month qualifier zero means don't-care, reset
// - Control bit 3 switches alarm features
// - Control bit 2 routes alarm to wake
// - Control bit 1 resets all but control
// - Soft reset bit self-clears, only power reset
// - Control bit 0 low halts internal operation
// - Weekday qualifier 1..7 must equal weekday
// - Top bits 11 make weekday don't-care, FFh
// - Bit 31 matches PM when 12-hour written
// - Bits 30:24 hour match, converted at write
// - Bits 18:16 match week of month
// - Bits 10:8 match weekday bits 2:0
// - Bits 7:0 match month counter
// - All fields match: advance one extra hour
// - Word or single byte writes accepted
// - Month and hour converted per format once
// - Alarm inside skipped hour never fires
// - Mode bit 0 enables daylight-saving, off reset
// - Mode bit 2 selects binary or BCD
// - Alarm flag sets on event, read clears
module rtq_alarm_qual
    import rtq_pkg::*;
(
    input wire logic clock_i,
    input wire logic nrst_i,
    input wire logic [7:0] addr_i,
    input wire logic [31:0] wdata_i,
    input wire logic wr_i,
    input wire logic wr_byte_i,
    input wire logic rd_i,
    output logic [31:0] rdata_o,
    input wire rtq_now_t now_i,
    input wire logic tod_match_i,
    input wire logic hour_tick_i,
    output logic alarm_event_o,
    output logic alarm_to_wake_circuit_o,
    output logic [1:0] hour_step_o,
    output logic block_run_o,
    output logic rtc_reset_o
);
    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    function automatic logic [7:0] to_internal(input logic [7:0] v, input logic bin);
        logic [7:0] tens;
        tens = {4'h0, v[7:4]};
        to_internal = bin ? v : 8'((tens << 3) + (tens << 1) + {4'h0, v[3:0]});
    endfunction : to_internal

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    logic run_en;
    logic soft_rst;
    logic wake_en;
    logic alarm_en;
    logic [2:0] rst_cnt;
    logic [2:0] mode;
    logic alarm_flag;
    logic [5:0] month_qual;
    logic [7:0] wday_qual;
    rtq_fwd_t fwd;
    logic fwd_12h;
    rtq_fwd_t next_fwd;
    logic next_fwd_12h;
    logic wr_fwd;
    logic month_ok;
    logic wday_ok;
    logic fwd_hit;
    logic fwd_fire;
    logic alarm_hit;
    logic flag_rd;

    assign rtc_reset_o = soft_rst;
    assign block_run_o = run_en;
    assign flag_rd = rd_i && addr_i == OFS_FLAG;

    // ------------------------------------------------------------
    // Control register: not touched by the block reset it starts
    // ------------------------------------------------------------
    always_ff @(posedge clock_i or negedge nrst_i) begin
        if (!nrst_i) begin
            run_en <= 1'b0;
            wake_en <= 1'b0;
            alarm_en <= 1'b0;
        end else if (wr_i && addr_i == OFS_CTRL) begin
            run_en <= wdata_i[CTRL_RUN];
            wake_en <= wdata_i[CTRL_WAKE];
            alarm_en <= wdata_i[CTRL_ALARM_EN];
        end
    end

    // A write of one during a running reset restarts the count
    always_ff @(posedge clock_i or negedge nrst_i) begin
        if (!nrst_i) begin
            soft_rst <= 1'b0;
            rst_cnt <= 3'h0;
        end else if (wr_i && addr_i == OFS_CTRL && wdata_i[CTRL_SOFT_RST]) begin
            soft_rst <= 1'b1;
            rst_cnt <= SOFT_RST_CYCLES;
        end else if (soft_rst) begin
            rst_cnt <= rst_cnt - 3'h1;
            if (rst_cnt == 3'h1) begin
                soft_rst <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------
    // Qualifier and mode registers, cleared by the block reset
    // ------------------------------------------------------------
    always_ff @(posedge clock_i or negedge nrst_i) begin
        if (!nrst_i) begin
            month_qual <= MONTH_DC;
        end else if (soft_rst) begin
            month_qual <= MONTH_DC;
        end else if (wr_i && addr_i == OFS_MONTH_QUAL) begin
            month_qual <= wdata_i[5:0];
        end
    end

    always_ff @(posedge clock_i or negedge nrst_i) begin
        if (!nrst_i) begin
            wday_qual <= WDAY_DC_RESET;
        end else if (soft_rst) begin
            wday_qual <= WDAY_DC_RESET;
        end else if (wr_i && addr_i == OFS_WDAY_QUAL) begin
            wday_qual <= (wdata_i[7:6] == WDAY_DC_TOP) ? WDAY_DC_RESET : wdata_i[7:0];
        end
    end

    always_ff @(posedge clock_i or negedge nrst_i) begin
        if (!nrst_i) begin
            mode <= 3'h0;
        end else if (soft_rst) begin
            mode <= 3'h0;
        end else if (wr_i && addr_i == OFS_MODE) begin
            mode <= wdata_i[2:0];
        end
    end

    // ------------------------------------------------------------
    // Spring-forward register: word write at base, byte writes at base+n
    // ------------------------------------------------------------
    assign wr_fwd = wr_i && addr_i[7:2] == OFS_FWD[7:2] && (wr_byte_i || addr_i[1:0] == 2'h0);

    always_comb begin
        logic [31:0] raw;
        logic [7:0] hbyte;
        raw = fwd;
        hbyte = 8'h00;
        next_fwd_12h = fwd_12h;
        if (!wr_byte_i) begin
            raw = wdata_i;
        end else begin
            case (addr_i[1:0])
                2'h0: raw[7:0] = wdata_i[7:0];
                2'h1: raw[15:8] = wdata_i[7:0];
                2'h2: raw[23:16] = wdata_i[7:0];
                default: raw[31:24] = wdata_i[7:0];
            endcase
        end
        next_fwd = raw;
        next_fwd.rsv_hi = '0;
        next_fwd.rsv_lo = '0;
        // Month and hour follow the format in force now; week and weekday stay raw
        if (!wr_byte_i || addr_i[1:0] == 2'h0) begin
            next_fwd.month = to_internal(raw[7:0], mode[MODE_BIN]);
        end
        if (!wr_byte_i || addr_i[1:0] == FWD_BYTE_LAST) begin
            hbyte = to_internal({1'b0, raw[30:24]}, mode[MODE_BIN]);
            next_fwd.hour = hbyte[6:0];
            next_fwd_12h = !mode[MODE_H24];
        end
    end

    always_ff @(posedge clock_i or negedge nrst_i) begin
        if (!nrst_i) begin
            fwd <= FWD_RESET;
            fwd_12h <= 1'b0;
        end else if (soft_rst) begin
            fwd <= FWD_RESET;
            fwd_12h <= 1'b0;
        end else if (wr_fwd) begin
            fwd <= next_fwd;
            fwd_12h <= next_fwd_12h;
        end
    end

    // ------------------------------------------------------------
    // Matching
    // ------------------------------------------------------------
    // No don't-care fields here: software must load them all first
    assign fwd_hit = fwd.hour == now_i.hours[6:0]
        && (!fwd_12h || fwd.ampm == now_i.hours[HOUR_PM])
        && fwd.week == now_i.week
        && fwd.wday == now_i.weekday[2:0]
        && fwd.month == now_i.month;
    assign fwd_fire = run_en && !soft_rst && mode[MODE_DST] && hour_tick_i && fwd_hit;

    assign month_ok = month_qual == MONTH_DC || {2'h0, month_qual} == now_i.month;
    assign wday_ok = wday_qual < WDAY_MIN || wday_qual > WDAY_MAX || wday_qual == now_i.weekday;
    // The tick that jumps over the hour carries no alarm
    assign alarm_hit = run_en && !soft_rst && alarm_en && tod_match_i && month_ok && wday_ok
        && !fwd_fire;

    // ------------------------------------------------------------
    // Outputs to the counters and the wake logic
    // ------------------------------------------------------------
    always_ff @(posedge clock_i or negedge nrst_i) begin
        if (!nrst_i) begin
            hour_step_o <= STEP_NONE;
        end else if (fwd_fire) begin
            hour_step_o <= STEP_TWO;
        end else if (run_en && !soft_rst && hour_tick_i) begin
            hour_step_o <= STEP_ONE;
        end else begin
            hour_step_o <= STEP_NONE;
        end
    end

    always_ff @(posedge clock_i or negedge nrst_i) begin
        if (!nrst_i) begin
            alarm_event_o <= 1'b0;
            alarm_to_wake_circuit_o <= 1'b0;
        end else begin
            alarm_event_o <= alarm_hit;
            alarm_to_wake_circuit_o <= alarm_hit && wake_en;
        end
    end

    // Set beats the read that would clear it
    always_ff @(posedge clock_i or negedge nrst_i) begin
        if (!nrst_i) begin
            alarm_flag <= 1'b0;
        end else if (soft_rst) begin
            alarm_flag <= 1'b0;
        end else if (alarm_hit) begin
            alarm_flag <= 1'b1;
        end else if (flag_rd) begin
            alarm_flag <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // Read port: data in the cycle after the strobe only
    // ------------------------------------------------------------
    always_ff @(posedge clock_i or negedge nrst_i) begin
        if (!nrst_i) begin
            rdata_o <= 32'h0000_0000;
        end else if (!rd_i) begin
            rdata_o <= 32'h0000_0000;
        end else begin
            case (addr_i)
                OFS_MODE: rdata_o <= {29'h0, mode};
                OFS_FLAG: rdata_o <= 32'(alarm_flag) << FLAG_ALARM;
                OFS_MONTH_QUAL: rdata_o <= {26'h0, month_qual};
                OFS_CTRL: rdata_o <= {28'h0, alarm_en, wake_en, soft_rst, run_en};
                OFS_WDAY_QUAL: rdata_o <= {24'h0, wday_qual};
                OFS_FWD: rdata_o <= fwd;
                default: rdata_o <= 32'h0000_0000;
            endcase
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (!nrst_i);

    sequence s_soft_start;
        wr_i && addr_i == OFS_CTRL && wdata_i[CTRL_SOFT_RST];
    endsequence
    sequence s_soft_hold;
        soft_rst [*4] ##1 !soft_rst;
    endsequence
    sequence s_clean_ctrl;
        !(wr_i && addr_i == OFS_CTRL) [*5];
    endsequence

    property p_soft_len;
        s_soft_start ##1 s_clean_ctrl |-> !soft_rst && rst_cnt == 3'h0;
    endproperty
    a_soft_len: assert property (p_soft_len) else $error("soft reset did not self clear");
    property p_soft_pulse;
        s_soft_start |=> s_soft_hold or (##[1:4] (wr_i && addr_i == OFS_CTRL));
    endproperty
    a_soft_pulse: assert property (p_soft_pulse) else $error("soft reset not four cycles");
    property p_ctrl_kept;
        soft_rst && !(wr_i && addr_i == OFS_CTRL) |=> $stable(run_en) && $stable(alarm_en) && $stable(wake_en);
    endproperty
    a_ctrl_kept: assert property (p_ctrl_kept) else $error("control changed by block reset");
    property p_month_block;
        month_qual != MONTH_DC && {2'h0, month_qual} != now_i.month |=> !alarm_event_o;
    endproperty
    a_month_block: assert property (p_month_block) else $error("month qualifier ignored");
    property p_month_dc;
        run_en && !soft_rst && alarm_en && tod_match_i && month_qual == MONTH_DC && wday_qual == WDAY_DC_RESET
            && !fwd_fire |=> alarm_event_o;
    endproperty
    a_month_dc: assert property (p_month_dc) else $error("don't-care month blocked alarm");
    property p_alarm_off;
        !alarm_en || !run_en |=> !alarm_event_o && !alarm_to_wake_circuit_o;
    endproperty
    a_alarm_off: assert property (p_alarm_off) else $error("alarm while disabled");
    property p_wake_gate;
        ##1 alarm_to_wake_circuit_o |-> alarm_event_o && $past(wake_en);
    endproperty
    a_wake_gate: assert property (p_wake_gate) else $error("wake without routing");
    property p_run_gate;
        !run_en |=> hour_step_o == STEP_NONE;
    endproperty
    a_run_gate: assert property (p_run_gate) else $error("step while halted");
    property p_wday_block;
        wday_qual >= WDAY_MIN && wday_qual <= WDAY_MAX && wday_qual != now_i.weekday |=> !alarm_event_o;
    endproperty
    a_wday_block: assert property (p_wday_block) else $error("weekday qualifier ignored");
    property p_wday_dc;
        wr_i && addr_i == OFS_WDAY_QUAL && wdata_i[7:6] == WDAY_DC_TOP && !soft_rst |=> wday_qual == WDAY_DC_RESET;
    endproperty
    a_wday_dc: assert property (p_wday_dc) else $error("weekday don't-care not FFh");
    property p_fwd_step;
        fwd_fire |=> hour_step_o == STEP_TWO ##1 hour_step_o != STEP_TWO || $past(fwd_fire);
    endproperty
    a_fwd_step: assert property (p_fwd_step) else $error("extra hour missing");
    property p_skip_alarm;
        fwd_fire |=> !alarm_event_o;
    endproperty
    a_skip_alarm: assert property (p_skip_alarm) else $error("alarm in skipped hour");
    property p_flag_set;
        alarm_event_o |-> alarm_flag;
    endproperty
    a_flag_set: assert property (p_flag_set) else $error("flag missed alarm");
    property p_flag_read;
        flag_rd && alarm_flag && !alarm_hit && !soft_rst |=> !alarm_flag && rdata_o[FLAG_ALARM];
    endproperty
    a_flag_read: assert property (p_flag_read) else $error("flag read clear wrong");
    // A live hour tick that misses any one field must give the plain step
    logic tick_live;
    assign tick_live = run_en && !soft_rst && hour_tick_i;
    property p_fwd_hour;
        tick_live && mode[MODE_DST] && fwd.hour != now_i.hours[6:0] |=> hour_step_o == STEP_ONE;
    endproperty
    a_fwd_hour: assert property (p_fwd_hour) else $error("hour mismatch still jumped");
    property p_fwd_ampm;
        tick_live && mode[MODE_DST] && fwd_12h && fwd.ampm != now_i.hours[HOUR_PM] |=> hour_step_o == STEP_ONE;
    endproperty
    a_fwd_ampm: assert property (p_fwd_ampm) else $error("pm mismatch still jumped");
    property p_fwd_week;
        tick_live && mode[MODE_DST] && fwd.week != now_i.week |=> hour_step_o == STEP_ONE;
    endproperty
    a_fwd_week: assert property (p_fwd_week) else $error("week mismatch still jumped");
    property p_fwd_wday;
        tick_live && mode[MODE_DST] && fwd.wday != now_i.weekday[2:0] |=> hour_step_o == STEP_ONE;
    endproperty
    a_fwd_wday: assert property (p_fwd_wday) else $error("weekday mismatch still jumped");
    property p_fwd_month;
        tick_live && mode[MODE_DST] && fwd.month != now_i.month |=> hour_step_o == STEP_ONE;
    endproperty
    a_fwd_month: assert property (p_fwd_month) else $error("month mismatch still jumped");
    property p_dst_off;
        tick_live && !mode[MODE_DST] |=> hour_step_o == STEP_ONE;
    endproperty
    a_dst_off: assert property (p_dst_off) else $error("jump with daylight saving off");
    property p_rsv_zero;
        wr_fwd |=> fwd.rsv_hi == 5'h00 && fwd.rsv_lo == 5'h00;
    endproperty
    a_rsv_zero: assert property (p_rsv_zero) else $error("reserved spring bits stored");
    property p_alarm_needs;
        alarm_event_o |-> $past(run_en) && $past(alarm_en) && $past(tod_match_i);
    endproperty
    a_alarm_needs: assert property (p_alarm_needs) else $error("alarm without run, enable or time");
endmodule : rtq_alarm_qual

// ===== rtl/rtq_pkg.sv
// Package: register map, field layout, reset values and carriers of the alarm qualifier block
package rtq_pkg;
    // ------------------------------------------------------------
    // Register offsets (byte addresses)
    // ------------------------------------------------------------
    localparam logic [7:0] OFS_MODE = 8'h0b;
    localparam logic [7:0] OFS_FLAG = 8'h0c;
    localparam logic [7:0] OFS_MONTH_QUAL = 8'h0d;
    localparam logic [7:0] OFS_CTRL = 8'h10;
    localparam logic [7:0] OFS_WDAY_QUAL = 8'h14;
    localparam logic [7:0] OFS_FWD = 8'h18;
    localparam logic [1:0] FWD_BYTE_LAST = 2'h3;
    // ------------------------------------------------------------
    // Field positions and reset values
    // ------------------------------------------------------------
    localparam int CTRL_RUN = 0;
    localparam int CTRL_SOFT_RST = 1;
    localparam int CTRL_WAKE = 2;
    localparam int CTRL_ALARM_EN = 3;
    localparam int MODE_DST = 0;
    localparam int MODE_H24 = 1;
    localparam int MODE_BIN = 2;
    localparam int FLAG_ALARM = 5;
    localparam int HOUR_PM = 7;
    localparam logic [7:0] WDAY_DC_RESET = 8'hff;
    localparam logic [1:0] WDAY_DC_TOP = 2'h3;
    localparam logic [7:0] WDAY_MIN = 8'h01;
    localparam logic [7:0] WDAY_MAX = 8'h07;
    localparam logic [5:0] MONTH_DC = 6'h00;
    localparam logic [2:0] SOFT_RST_CYCLES = 3'h4;
    localparam logic [1:0] STEP_NONE = 2'h0;
    localparam logic [1:0] STEP_ONE = 2'h1;
    localparam logic [1:0] STEP_TWO = 2'h2;
    // ------------------------------------------------------------
    // Carriers
    // ------------------------------------------------------------
    // Current counter contents, binary, hours bit 7 is PM in 12-hour mode
    typedef struct packed {
        logic [7:0] hours;
        logic [7:0] month;
        logic [7:0] weekday;
        logic [2:0] week;
    } rtq_now_t;
    // Spring-forward match register layout
    typedef struct packed {
        logic ampm;
        logic [6:0] hour;
        logic [4:0] rsv_hi;
        logic [2:0] week;
        logic [4:0] rsv_lo;
        logic [2:0] wday;
        logic [7:0] month;
    } rtq_fwd_t;
    localparam rtq_fwd_t FWD_RESET = '0;
endpackage : rtq_pkg

// ===== testbench/rtq_alarm_qual_tb.sv
// Self-checking testbench of the alarm qualifier and spring-forward block
`timescale 1ns/100ps
module rtq_alarm_qual_tb;
    import rtq_pkg::*;
    // ------------------------------------------------------------
    // Signals and instance
    // ------------------------------------------------------------
    logic clock_i = 1'b0;
    logic nrst_i = 1'b0;
    logic [7:0] addr = 8'h00;
    logic [31:0] wdata = 32'h0;
    logic wr = 1'b0;
    logic wr_byte = 1'b0;
    logic rd = 1'b0;
    logic [31:0] rdata;
    rtq_now_t now = '0;
    logic tod = 1'b0;
    logic tick = 1'b0;
    logic alarm_ev;
    logic wake;
    logic [1:0] step;
    logic run;
    logic rtc_rst;
    int err_count = 0;
    int num_checks = 0;
    always #4 clock_i = ~clock_i;
    rtq_alarm_qual i_rtq_alarm_qual (.clock_i(clock_i), .nrst_i(nrst_i), .addr_i(addr), .wdata_i(wdata),
        .wr_i(wr), .wr_byte_i(wr_byte), .rd_i(rd), .rdata_o(rdata), .now_i(now), .tod_match_i(tod),
        .hour_tick_i(tick), .alarm_event_o(alarm_ev), .alarm_to_wake_circuit_o(wake), .hour_step_o(step),
        .block_run_o(run), .rtc_reset_o(rtc_rst));
    // ------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
        num_checks++;
        if (got !== exp) begin
            err_count++;
            $display("CHECK FAILED at %0t: %s got %h expected %h", $time, msg, got, exp);
        end
    endtask : chk
    task automatic reg_wr(input logic [7:0] a, input logic [31:0] d, input logic b);
        @(posedge clock_i);
        wr <= 1'b1;
        wr_byte <= b;
        addr <= a;
        wdata <= d;
        @(posedge clock_i);
        wr <= 1'b0;
        wr_byte <= 1'b0;
    endtask : reg_wr
    task automatic reg_rd(input logic [7:0] a, input logic [31:0] exp, input string msg);
        @(posedge clock_i);
        rd <= 1'b1;
        addr <= a;
        @(posedge clock_i);
        rd <= 1'b0;
        #1;
        chk(rdata, exp, msg);
    endtask : reg_rd
    task automatic set_now(input logic [7:0] h, input logic [7:0] m, input logic [7:0] wd, input logic [2:0] wk);
        @(posedge clock_i);
        now <= '{hours: h, month: m, weekday: wd, week: wk};
    endtask : set_now
    // Hit is sampled at the next edge, so the event is looked at just after it
    task automatic alm(input logic ev, input logic wk, input string msg);
        @(posedge clock_i);
        #1;
        chk({31'h0, alarm_ev}, {31'h0, ev}, msg);
        chk({31'h0, wake}, {31'h0, wk}, msg);
    endtask : alm
    task automatic hour_tick(input logic [1:0] exp, input string msg);
        @(posedge clock_i);
        tick <= 1'b1;
        @(posedge clock_i);
        tick <= 1'b0;
        #1;
        chk({30'h0, step}, {30'h0, exp}, msg);
    endtask : hour_tick
    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic t_reset_values;
        reg_rd(OFS_MONTH_QUAL, 32'h0, "month qual reset");
        reg_rd(OFS_CTRL, 32'h0, "control reset");
        reg_rd(OFS_WDAY_QUAL, 32'hff, "weekday qual reset");
        reg_rd(OFS_FWD, 32'h0, "spring reset");
        reg_rd(8'h30, 32'h0, "unmapped read");
    endtask : t_reset_values
    task automatic t_weekday_qual;
        reg_wr(OFS_WDAY_QUAL, 32'hc5, 1'b0);
        reg_rd(OFS_WDAY_QUAL, 32'hff, "top bits make don't care");
        reg_wr(OFS_WDAY_QUAL, 32'h03, 1'b0);
        reg_rd(OFS_WDAY_QUAL, 32'h03, "weekday qual stored");
    endtask : t_weekday_qual
    task automatic t_alarm;
        reg_wr(OFS_CTRL, 32'h0d, 1'b0);
        set_now(8'h02, 8'h06, 8'h03, 3'h1);
        tod <= 1'b1;
        alm(1'b1, 1'b1, "weekday equal fires and wakes");
        chk({31'h0, run}, 32'h1, "run output high");
        set_now(8'h02, 8'h06, 8'h04, 3'h1);
        alm(1'b0, 1'b0, "weekday differs blocks");
        reg_wr(OFS_WDAY_QUAL, 32'hff, 1'b0);
        alm(1'b1, 1'b1, "weekday don't care");
        reg_wr(OFS_MONTH_QUAL, 32'h05, 1'b0);
        alm(1'b0, 1'b0, "month differs blocks");
        set_now(8'h02, 8'h05, 8'h04, 3'h1);
        alm(1'b1, 1'b1, "month equal fires");
        reg_wr(OFS_MONTH_QUAL, 32'h00, 1'b0);
        set_now(8'h02, 8'h09, 8'h04, 3'h1);
        alm(1'b1, 1'b1, "month don't care");
        reg_wr(OFS_CTRL, 32'h09, 1'b0);
        alm(1'b1, 1'b0, "wake route off");
        reg_wr(OFS_CTRL, 32'h05, 1'b0);
        alm(1'b0, 1'b0, "alarm features off");
        reg_wr(OFS_CTRL, 32'h0c, 1'b0);
        alm(1'b0, 1'b0, "block halted");
        chk({31'h0, run}, 32'h0, "run output low");
        @(posedge clock_i);
        tod <= 1'b0;
        reg_wr(OFS_CTRL, 32'h0d, 1'b0);
        alm(1'b0, 1'b0, "no time match no event");
        reg_rd(OFS_FLAG, 32'h20, "flag set by events");
        reg_rd(OFS_FLAG, 32'h0, "flag cleared by read");
    endtask : t_alarm
    task automatic t_spring_bin;
        reg_wr(8'h0b, 32'h06, 1'b0);
        reg_wr(OFS_FWD, {1'b0, 7'd2, 5'h0, 3'd1, 5'h0, 3'd3, 8'd3}, 1'b0);
        reg_wr(8'h0b, 32'h07, 1'b0);
        reg_rd(OFS_FWD, 32'h02010303, "spring word read");
        set_now(8'h02, 8'h03, 8'h03, 3'h1);
        tod <= 1'b1;
        hour_tick(STEP_TWO, "all fields match");
        chk({31'h0, alarm_ev}, 32'h0, "alarm in skipped hour");
        @(posedge clock_i);
        tod <= 1'b0;
        set_now(8'h02, 8'h03, 8'h03, 3'h5);
        hour_tick(STEP_ONE, "week differs");
        set_now(8'h02, 8'h03, 8'h0b, 3'h1);
        hour_tick(STEP_TWO, "weekday low bits match");
        set_now(8'h03, 8'h03, 8'h03, 3'h1);
        hour_tick(STEP_ONE, "hour differs");
        set_now(8'h02, 8'h04, 8'h03, 3'h1);
        hour_tick(STEP_ONE, "month differs");
        reg_wr(8'h0b, 32'h06, 1'b0);
        reg_wr(OFS_FWD, 32'h04, 1'b1);
        reg_rd(OFS_FWD, 32'h02010304, "byte write month");
        hour_tick(STEP_ONE, "update disabled");
        reg_wr(8'h0b, 32'h07, 1'b0);
        hour_tick(STEP_TWO, "byte written month matches");
    endtask : t_spring_bin
    task automatic t_spring_bcd;
        reg_wr(8'h0b, 32'h00, 1'b0);
        reg_wr(OFS_FWD, {1'b1, 7'h11, 5'h0, 3'd2, 5'h0, 3'd5, 8'h12}, 1'b0);
        reg_wr(8'h0b, 32'h01, 1'b0);
        set_now(8'h8b, 8'h0c, 8'h05, 3'h2);
        hour_tick(STEP_TWO, "bcd fields converted");
        set_now(8'h0b, 8'h0c, 8'h05, 3'h2);
        hour_tick(STEP_ONE, "pm differs in 12 hour");
        reg_wr(8'h0b, 32'h07, 1'b0);
        set_now(8'h8b, 8'h0c, 8'h05, 3'h2);
        hour_tick(STEP_TWO, "format change keeps values");
        // Daylight saving is switched off around the byte write of the hour lane
        reg_wr(8'h0b, 32'h00, 1'b0);
        reg_wr(8'h1b, 32'h92, 1'b1);
        reg_wr(8'h0b, 32'h01, 1'b0);
        set_now(8'h8c, 8'h0c, 8'h05, 3'h2);
        hour_tick(STEP_TWO, "bcd hour byte write");
    endtask : t_spring_bcd
    task automatic t_soft_reset;
        int n;
        n = 0;
        reg_wr(OFS_MONTH_QUAL, 32'h07, 1'b0);
        reg_wr(OFS_WDAY_QUAL, 32'h02, 1'b0);
        reg_rd(OFS_WDAY_QUAL, 32'h02, "weekday qual stored");
        reg_wr(OFS_CTRL, 32'h0f, 1'b0);
        // Counting starts in the cycle of the write edge itself
        repeat (8) begin
            #1;
            if (rtc_rst === 1'b1) n++;
            @(posedge clock_i);
        end
        chk(n, {29'h0, SOFT_RST_CYCLES}, "reset length");
        reg_rd(OFS_CTRL, 32'h0d, "control kept, bit self clears");
        reg_rd(OFS_MONTH_QUAL, 32'h0, "month qual reset");
        reg_rd(OFS_WDAY_QUAL, 32'hff, "weekday qual reset");
        reg_rd(OFS_FWD, 32'h0, "spring reset");
        reg_rd(8'h0b, 32'h0, "mode reset");
    endtask : t_soft_reset
    // ------------------------------------------------------------
    // Sequence, watchdog and verdict
    // ------------------------------------------------------------
    task automatic close_out;
        $display("checks %0d errors %0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : close_out
    initial begin
        repeat (5) @(posedge clock_i);
        nrst_i <= 1'b1;
        t_reset_values();
        t_weekday_qual();
        t_alarm();
        t_spring_bin();
        t_spring_bcd();
        t_soft_reset();
        close_out();
    end
    // Whole run is about 150 cycles; this limit only catches a hang
    initial begin
        #100000;
        err_count++;
        close_out();
    end
endmodule : rtq_alarm_qual_tb
